/* File: verilog/rtc_drift_calibration.sv */
// drift calibration of the one-second tick derived from the slow clock
// Functional notes
// - slow clock untouched; only the derived one-second period is adjusted
// - correction every 1 + (20 - 19*range) * magnitude seconds
// - corrected second lengthened or shortened by about 4 ms per sign
// - positive and negative correction spanning about 1.6 to 2000 ppm
// - settings accepted while running; no stop of the time base
`timescale 1ns/100ps
module rtc_drift_calibration (
    input  wire logic                     sys_clk,
    input  wire logic                     nrst,
    input  wire logic                     slow_clk,
    input  wire rtc_cal_pkg::cal_cfg_t    cal_cfg,
    output logic                          sec_tick,
    output logic                          cal_applied
);
    logic [2:0]                    slow_sync;
    logic [rtc_cal_pkg::DIV_W-1:0] div;
    rtc_cal_pkg::cal_cfg_t         cfg;
    rtc_cal_pkg::sec_mode_t        mode;
    rtc_cal_pkg::sec_mode_t        next_mode;
    logic [rtc_cal_pkg::DIV_W-1:0] next_last;
    wire                           slow_edge;
    wire                           sec_end;
    wire                           due;

    // two flops before use; the third only forms the edge detector
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            slow_sync <= 3'h0;
        else
            slow_sync <= {slow_sync[1:0], slow_clk};
    end

    // slow clock is only sampled, never regenerated or retimed
    assign slow_edge = slow_sync[1] & ~slow_sync[2];

    // terminal count of the second in progress
    always_comb
    begin
        case (mode)
            rtc_cal_pkg::ST_LONG:   next_last = rtc_cal_pkg::SLOW_LAST
                                               + rtc_cal_pkg::ADJ_CYCLES;
            rtc_cal_pkg::ST_SHORT:  next_last = rtc_cal_pkg::SLOW_LAST
                                               - rtc_cal_pkg::ADJ_CYCLES;
            default:                next_last = rtc_cal_pkg::SLOW_LAST;
        endcase
    end

    assign sec_end = slow_edge && (div >= next_last);

    rtc_cal_gap gap_u (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .sec_tick (sec_end),
        .cfg      (cfg),
        .due      (due)
    );

    // sign chooses direction; both signs share one scheduler
    always_comb
    begin
        if (!due)
            next_mode = rtc_cal_pkg::ST_NORMAL;
        else if (cfg.negative_sign_select)
            next_mode = rtc_cal_pkg::ST_LONG;
        else
            next_mode = rtc_cal_pkg::ST_SHORT;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            div <= rtc_cal_pkg::SLOW_DIV_RESET;
        else if (sec_end)
            div <= rtc_cal_pkg::SLOW_DIV_RESET;
        else if (slow_edge)
            div <= div + 1'b1;
    end

    // config sampled only at a second boundary, so a second never mixes settings
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg  <= '0;
            mode <= rtc_cal_pkg::ST_NORMAL;
        end
        else if (sec_end)
        begin
            cfg  <= cal_cfg;
            mode <= next_mode;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sec_tick    <= 1'b0;
            cal_applied <= 1'b0;
        end
        else
        begin
            sec_tick    <= sec_end;
            cal_applied <= sec_end && (mode != rtc_cal_pkg::ST_NORMAL);
        end
    end
endmodule : rtc_drift_calibration

/* File: verilog/rtc_cal_pkg.sv */
// package: constants and types for the one-second drift calibration
package rtc_cal_pkg;
    localparam int          CORR_W          = 7;
    localparam int          DIV_W           = 16;
    localparam int          GAP_W           = 12;
    localparam logic [15:0] SLOW_HZ         = 16'h8000;  // 32768 slow clock cycles per second
    localparam logic [15:0] SLOW_LAST       = 16'h7fff;
    localparam logic [15:0] ADJ_CYCLES      = 16'h0083;  // 131 slow cycles, about 4 ms
    localparam logic [4:0]  GAP_LOW_MULT    = 5'h14;     // 20 s per step in low range
    localparam logic [4:0]  GAP_HIGH_MULT   = 5'h01;     // 20 - 19 in high range
    localparam logic [15:0] SLOW_DIV_RESET  = 16'h0000;
    localparam logic [11:0] GAP_RESET       = 12'h000;

    typedef struct packed {
        logic [CORR_W-1:0] magnitude;
        logic              negative_sign_select;
        logic              coarse_range_select;
    } cal_cfg_t;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_LONG   = 2'b01,
        ST_SHORT  = 2'b10
    } sec_mode_t;
endpackage : rtc_cal_pkg

/* File: verilog/rtc_cal_gap.sv */
// correction interval counter: pulses when the next second must be adjusted
`timescale 1ns/100ps
module rtc_cal_gap (
    input  wire logic                     sys_clk,
    input  wire logic                     nrst,
    input  wire logic                     sec_tick,
    input  wire rtc_cal_pkg::cal_cfg_t    cfg,
    output logic                          due
);
    logic [rtc_cal_pkg::GAP_W-1:0] gap;
    wire  [4:0]                    mult;
    wire  [rtc_cal_pkg::GAP_W-1:0] span;
    wire                           at_end;

    // interval = 1 + mult*corr seconds; counter runs 0..mult*corr
    assign mult   = cfg.coarse_range_select ? rtc_cal_pkg::GAP_HIGH_MULT
                                            : rtc_cal_pkg::GAP_LOW_MULT;
    // widen both factors first: 20 * 127 needs all twelve bits
    assign span   = rtc_cal_pkg::GAP_W'(mult)
                  * rtc_cal_pkg::GAP_W'(cfg.magnitude);
    assign at_end = (gap >= span);
    // zero magnitude never flags a correction
    assign due    = at_end && (cfg.magnitude != '0);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            gap <= rtc_cal_pkg::GAP_RESET;
        else if (sec_tick)
            gap <= at_end ? rtc_cal_pkg::GAP_RESET : gap + 1'b1;
    end
endmodule : rtc_cal_gap

/* File: verification/rtc_drift_calibration_asserts.sv */
// checker: tick width, second length and correction sign
`timescale 1ns/100ps
module rtc_drift_calibration_asserts (
    input wire logic                  sys_clk,
    input wire logic                  nrst,
    input wire logic                  slow_clk,
    input wire rtc_cal_pkg::cal_cfg_t cal_cfg,
    input wire logic                  sec_tick,
    input wire logic                  cal_applied
);
    logic [16:0]           n;
    logic                  s;
    logic                  v;
    logic                  ng;
    logic                  mz;
    logic                  ng_now;
    logic                  mz_now;
    rtc_cal_pkg::cal_cfg_t cfg_d;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // first second skipped: sync skew at reset release may shift one edge
    always_ff @(posedge sys_clk or negedge nrst)
        if (!nrst) {n, s, v} <= '0;
        else {n, s, v} <= sec_tick ? {17'(slow_clk & !s), slow_clk, 1'b1}
            : {n + 17'(slow_clk & !s), slow_clk, v};
    // setting is taken one cycle before the tick and steers the second after next
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_d                    <= '0;
            {ng_now, mz_now, ng, mz} <= 4'b0101;
        end
        else
        begin
            cfg_d <= cal_cfg;
            if (sec_tick)
                {ng_now, mz_now, ng, mz} <= {cfg_d.negative_sign_select,
                    cfg_d.magnitude == 7'h00, ng_now, mz_now};
        end
    end
    a_tick_pulse: assert property (sec_tick |=> !sec_tick)
        else $error("tick wider than one cycle");
    a_applied_tick: assert property (cal_applied |-> sec_tick)
        else $error("correction flag without tick");
    a_second_len: assert property (sec_tick && v |->
        n inside {17'h08000, 17'h08083, 17'h07f7d})
        else $error("second length off");
    a_adjust_flag: assert property (sec_tick && v |-> cal_applied == (n != 17'h08000))
        else $error("correction flag disagrees with length");
    a_adjust_sign: assert property (cal_applied && v |-> (n > 17'h08000) == ng)
        else $error("correction in wrong direction");
    a_zero_off: assert property (cal_applied && v |-> !mz)
        else $error("correction with zero magnitude");
    cover property (sec_tick && v && !cal_applied);
    cover property (cal_applied && v && ng);
    cover property (cal_applied && v && !ng);
endmodule : rtc_drift_calibration_asserts

/* File: verification/test_rtc_drift_calibration.sv */
// testbench: one-second spacing with and without drift correction
`timescale 1ns/100ps
module test_rtc_drift_calibration;
    logic                  sys_clk = 1'b0, nrst = 1'b0, slow_clk = 1'b0, sec_tick, cal_applied;
    rtc_cal_pkg::cal_cfg_t cal_cfg = '0;
    int                    mismatches = 0, n_compared = 0, cyc = 0;
    always #2.5 sys_clk = ~sys_clk;
    // slow clock at half the system rate: a second is 65536 cycles, run stays long
    always @(negedge sys_clk) slow_clk <= ~slow_clk;
    rtc_drift_calibration u_dut (.sys_clk(sys_clk), .nrst(nrst), .slow_clk(slow_clk),
        .cal_cfg(cal_cfg), .sec_tick(sec_tick), .cal_applied(cal_applied));
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 800000)
        begin
            mismatches++;
            end_sim();
        end
    end
    task check(input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp)
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        mismatches += (seen !== exp);
    endtask : check
    // cfg changes just after a tick; plan marks the seconds due for correction
    task run(input logic [8:0] c, input int secs, input logic [3:0] plan, input logic [16:0] adj);
        logic [16:0] len;
        int          hits;
        int          i;
        hits = 0;
        cal_cfg = rtc_cal_pkg::cal_cfg_t'(c);
        for (i = 0; i < secs; i++)
        begin
            len = 17'h00000;
            do
            begin
                @(negedge sys_clk);
                len++;
            end
            while (sec_tick !== 1'b1);
            hits += (cal_applied === 1'b1);
            check(len, plan[i] ? adj : 17'h10000);
            check(17'(cal_applied), 17'(plan[i]));
        end
        check(17'(hits), 17'($countones(plan)));
    endtask : run
    // a setting reaches the scheduler one second after it is taken
    task t_slow_down;
        run(9'h003, 1, 4'b0000, 17'h10106);
        run(9'h007, 1, 4'b0000, 17'h10106);
        run(9'h007, 4, 4'b0100, 17'h10106);
        $display("test slow_down done");
    endtask : t_slow_down
    task t_speed_up;
        run(9'h005, 1, 4'b0001, 17'h10106);
        run(9'h005, 2, 4'b0010, 17'h0fefa);
        $display("test speed_up done");
    endtask : t_speed_up
    initial
    begin
        repeat (8) @(negedge sys_clk);
        nrst = 1'b1;
        do @(negedge sys_clk); while (sec_tick !== 1'b1);
        t_slow_down();
        t_speed_up();
        end_sim();
    end
endmodule : test_rtc_drift_calibration
bind rtc_drift_calibration rtc_drift_calibration_asserts u_chk (.sys_clk(sys_clk), .nrst(nrst),
    .slow_clk(slow_clk), .cal_cfg(cal_cfg), .sec_tick(sec_tick), .cal_applied(cal_applied));
